// file: core/nsg_defs.vh
// Constants for the nested servo gain loop: attribute ids, reset values,
// configuration bit positions and fixed-point conversion limits.
// Assumes inclusion by core/nsg_loop.v and by the testbench.
`ifndef NSG_DEFS_VH
`define NSG_DEFS_VH

// ----------------------------------------------------------------------
// Attribute identifiers for get and set access
// ----------------------------------------------------------------------
`define NSG_ATTR_VEL_FF     5'h00
`define NSG_ATTR_ACC_FF     5'h01
`define NSG_ATTR_POS_PG     5'h02
`define NSG_ATTR_POS_IG     5'h03
`define NSG_ATTR_VEL_PG     5'h04
`define NSG_ATTR_VEL_IG     5'h05
`define NSG_ATTR_VEL_OFS    5'h06
`define NSG_ATTR_TRQ_OFS    5'h07
`define NSG_ATTR_LOOP_CFG   5'h08
`define NSG_ATTR_INT_HOLD   5'h09
`define NSG_ATTR_OUT_LIM    5'h0a
`define NSG_ATTR_POS_ERR    5'h0b
`define NSG_ATTR_POS_INT    5'h0c
`define NSG_ATTR_SERVO_OUT  5'h0d

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define NSG_RST_GAIN        32'h00000000
`define NSG_RST_WORD        32'h00000000
`define NSG_RST_OUT_LIM     32'h7fffffff
`define NSG_RST_CFG         2'h0

// ----------------------------------------------------------------------
// Loop configuration bits
// ----------------------------------------------------------------------
`define NSG_CFG_VELSERVO    0
`define NSG_CFG_VELDRIVE    1

// ----------------------------------------------------------------------
// Float to Q16.16 conversion and arithmetic
// ----------------------------------------------------------------------
`define NSG_EXP_MIN         8'h6e
`define NSG_EXP_UNITY       8'h86
`define NSG_EXP_MAX         8'h8d
`define NSG_Q_SAT           32'h7fffffff
`define NSG_PCT_FULL        32'h00000064

`endif

// file: core/nsg_loop.v
// Nested position/velocity servo law for a multi-axis motion card.
// Assumes a planner that pulses coarse_tick once per coarse update, and
// controller software that drives one-cycle attribute get/set strobes.
`timescale 1ns/1ps
`default_nettype none
`include "nsg_defs.vh"

module nsg_loop #(
    parameter NAX = 2,                       // Number of axes
    parameter AXW = 1,                       // Axis select width
    parameter W   = 32                       // Data word width
) (
    // Clock and reset
    input  wire             mclk,
    input  wire             rst,
    // Planner tick, then commands and feedback, one word per axis, and cmd_moving, one bit per axis
    input  wire             coarse_tick,
    input  wire [NAX*W-1:0] cmd_pos,
    input  wire [NAX*W-1:0] cmd_vel,
    input  wire [NAX*W-1:0] cmd_acc,
    input  wire [NAX*W-1:0] act_pos,
    input  wire [NAX*W-1:0] act_vel,
    input  wire [NAX-1:0]   cmd_moving,
    // Attribute get and set access
    input  wire             attr_wr,
    input  wire             attr_rd,
    input  wire [AXW-1:0]   attr_axis,
    input  wire [4:0]       attr_id,
    input  wire [W-1:0]     attr_wdata,
    output wire [W-1:0]     attr_rdata,
    output wire             attr_rvalid,
    // Drive command
    output wire [NAX*W-1:0] servo_out,
    output wire [NAX-1:0]   servo_sat,
    output wire             servo_strobe
);

    // ------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------
    // Single-precision float to signed Q16.16, saturating
    function signed [31:0] f2q;
        input [31:0] f;
        reg   [7:0]  e;
        reg   [31:0] m;
        begin
            e = f[30:23];
            m = {8'h00, 1'b1, f[22:0]};
            if (e < `NSG_EXP_MIN)
                m = 32'h00000000;            // Too small or zero
            else if (e >= `NSG_EXP_MAX)
                m = `NSG_Q_SAT;              // Too large
            else if (e >= `NSG_EXP_UNITY)
                m = m << (e - `NSG_EXP_UNITY);
            else
                m = m >> (`NSG_EXP_UNITY - e);
            f2q = f[31] ? -m : m;
        end
    endfunction

    // Value times Q16.16 gain
    function signed [31:0] qmul;
        input signed [31:0] a;
        input signed [31:0] q;
        reg   signed [63:0] p;
        begin
            p = a * q;
            qmul = p[47:16];
        end
    endfunction

    // Value times float percentage, 100 passes it unscaled
    function signed [31:0] pct;
        input signed [31:0] a;
        input        [31:0] g;
        begin
            pct = qmul(a, f2q(g)) / $signed(`NSG_PCT_FULL);
        end
    endfunction

    // ------------------------------------------------------------------
    // Per-axis attribute storage
    // ------------------------------------------------------------------
    reg        [W-1:0] vff_q   [0:NAX-1];    // Velocity FF gain, float %
    reg        [W-1:0] aff_q   [0:NAX-1];    // Accel FF gain, float %
    reg        [W-1:0] ppg_q   [0:NAX-1];    // Position P gain, float
    reg        [W-1:0] pig_q   [0:NAX-1];    // Position I gain, float
    reg        [W-1:0] vpg_q   [0:NAX-1];    // Velocity P gain, float
    reg        [W-1:0] vig_q   [0:NAX-1];    // Velocity I gain, float
    reg signed [W-1:0] vofs_q  [0:NAX-1];    // Velocity offset
    reg signed [W-1:0] tofs_q  [0:NAX-1];    // Torque offset
    reg        [1:0]   cfg_q   [0:NAX-1];    // Loop configuration
    reg                hold_q  [0:NAX-1];    // Integrator hold enable
    reg signed [W-1:0] lim_q   [0:NAX-1];    // Output magnitude limit
    // Loop state
    reg signed [W-1:0] cp_q    [0:NAX-1];    // Latched command position
    reg signed [W-1:0] cv_q    [0:NAX-1];    // Latched command velocity
    reg signed [W-1:0] ca_q    [0:NAX-1];    // Latched command accel
    reg signed [W-1:0] ap_q    [0:NAX-1];    // Latched actual position
    reg signed [W-1:0] av_q    [0:NAX-1];    // Latched actual velocity
    reg                mv_q    [0:NAX-1];    // Latched motion flag
    reg signed [W-1:0] perr_q  [0:NAX-1];    // Last position error
    reg signed [W-1:0] pint_q  [0:NAX-1];    // Position integral
    reg signed [W-1:0] vint_q  [0:NAX-1];    // Velocity integral
    reg signed [W-1:0] out_q   [0:NAX-1];    // Servo output
    reg                sat_q   [0:NAX-1];    // Output saturated
    reg                upd_q;                // Compute stage pending
    reg                strobe_q;             // New output pulse
    reg        [W-1:0] rdata_q;              // Read data
    reg                rvalid_q;             // Read answer pulse

    // Combinational loop results
    reg signed [W-1:0] perr_c  [0:NAX-1];
    reg signed [W-1:0] verr_c  [0:NAX-1];
    reg signed [W-1:0] out_c   [0:NAX-1];
    reg                sat_c   [0:NAX-1];
    reg                hold_c  [0:NAX-1];
    reg signed [W-1:0] vcmd;                 // Velocity command scratch
    reg signed [W-1:0] u;                    // Unclamped output scratch
    integer            i;
    integer            k;

    // ------------------------------------------------------------------
    // Control law
    // ------------------------------------------------------------------
    // Evaluate all NAX axes from the inputs latched at the last tick
    always @*
    begin
        vcmd = 32'h00000000;
        u    = 32'h00000000;
        for (k = 0; k < NAX; k = k + 1)
        begin
            perr_c[k] = cp_q[k] - ap_q[k];
            if (cfg_q[k][`NSG_CFG_VELSERVO])
                vcmd = cv_q[k] + vofs_q[k];
            else
                vcmd = qmul(perr_c[k], f2q(ppg_q[k]))
                     + qmul(pint_q[k], f2q(pig_q[k]))
                     + pct(cv_q[k], vff_q[k])
                     + vofs_q[k];
            verr_c[k] = vcmd - av_q[k];
            if (cfg_q[k][`NSG_CFG_VELDRIVE])
                u = vcmd;
            else
                u = qmul(verr_c[k], f2q(vpg_q[k]))
                  + qmul(vint_q[k], f2q(vig_q[k]))
                  + pct(ca_q[k], aff_q[k])
                  + tofs_q[k];
            // Clamp to the configured magnitude
            if (u > lim_q[k])
            begin
                out_c[k] = lim_q[k];
                sat_c[k] = 1'b1;
            end
            else if (u < -lim_q[k])
            begin
                out_c[k] = -lim_q[k];
                sat_c[k] = 1'b1;
            end
            else
            begin
                out_c[k] = u;
                sat_c[k] = 1'b0;
            end
            hold_c[k] = sat_c[k] | (hold_q[k] & mv_q[k]);
        end
    end

    // ------------------------------------------------------------------
    // Registers: attributes, input latch, integrators, outputs
    // ------------------------------------------------------------------
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (i = 0; i < NAX; i = i + 1)
            begin
                vff_q[i]  <= `NSG_RST_GAIN;
                aff_q[i]  <= `NSG_RST_GAIN;
                ppg_q[i]  <= `NSG_RST_GAIN;
                pig_q[i]  <= `NSG_RST_GAIN;
                vpg_q[i]  <= `NSG_RST_GAIN;
                vig_q[i]  <= `NSG_RST_GAIN;
                vofs_q[i] <= `NSG_RST_WORD;
                tofs_q[i] <= `NSG_RST_WORD;
                cfg_q[i]  <= `NSG_RST_CFG;
                hold_q[i] <= 1'b0;
                lim_q[i]  <= `NSG_RST_OUT_LIM;
                cp_q[i]   <= `NSG_RST_WORD;
                cv_q[i]   <= `NSG_RST_WORD;
                ca_q[i]   <= `NSG_RST_WORD;
                ap_q[i]   <= `NSG_RST_WORD;
                av_q[i]   <= `NSG_RST_WORD;
                mv_q[i]   <= 1'b0;
                perr_q[i] <= `NSG_RST_WORD;
                pint_q[i] <= `NSG_RST_WORD;
                vint_q[i] <= `NSG_RST_WORD;
                out_q[i]  <= `NSG_RST_WORD;
                sat_q[i]  <= 1'b0;
            end
            upd_q    <= 1'b0;
            strobe_q <= 1'b0;
            rdata_q  <= `NSG_RST_WORD;
            rvalid_q <= 1'b0;
        end
        else
        begin
            upd_q    <= coarse_tick;
            strobe_q <= upd_q;
            rvalid_q <= attr_rd;
            for (i = 0; i < NAX; i = i + 1)
            begin
                // Sample planner and feedback once per coarse update
                if (coarse_tick)
                begin
                    cp_q[i] <= cmd_pos[i*W +: W];
                    cv_q[i] <= cmd_vel[i*W +: W];
                    ca_q[i] <= cmd_acc[i*W +: W];
                    ap_q[i] <= act_pos[i*W +: W];
                    av_q[i] <= act_vel[i*W +: W];
                    mv_q[i] <= cmd_moving[i];
                end
                // Servo update one cycle after the sample
                if (upd_q)
                begin
                    perr_q[i] <= perr_c[i];
                    out_q[i]  <= out_c[i];
                    sat_q[i]  <= sat_c[i];
                    if (!hold_c[i] && !cfg_q[i][`NSG_CFG_VELSERVO])
                        pint_q[i] <= pint_q[i] + perr_c[i];
                    if (!hold_c[i] && !cfg_q[i][`NSG_CFG_VELDRIVE])
                        vint_q[i] <= vint_q[i] + verr_c[i];
                end
                // Attribute set, any time
                if (attr_wr && attr_axis == i)
                begin
                    case (attr_id)
                        `NSG_ATTR_VEL_FF:   vff_q[i]  <= attr_wdata;
                        `NSG_ATTR_ACC_FF:   aff_q[i]  <= attr_wdata;
                        `NSG_ATTR_POS_PG:   ppg_q[i]  <= attr_wdata;
                        `NSG_ATTR_POS_IG:   pig_q[i]  <= attr_wdata;
                        `NSG_ATTR_VEL_PG:   vpg_q[i]  <= attr_wdata;
                        `NSG_ATTR_VEL_IG:   vig_q[i]  <= attr_wdata;
                        `NSG_ATTR_VEL_OFS:  vofs_q[i] <= attr_wdata;
                        `NSG_ATTR_TRQ_OFS:  tofs_q[i] <= attr_wdata;
                        `NSG_ATTR_LOOP_CFG: cfg_q[i]  <= attr_wdata[1:0];
                        `NSG_ATTR_INT_HOLD: hold_q[i] <= attr_wdata[0];
                        `NSG_ATTR_OUT_LIM:  lim_q[i]  <= {1'b0, attr_wdata[W-2:0]};
                        default:            ;        // Read-only or unmapped
                    endcase
                end
            end
            // Attribute get, answered on the next cycle
            if (attr_rd)
            begin
                case (attr_id)
                    `NSG_ATTR_VEL_FF:    rdata_q <= vff_q[attr_axis];
                    `NSG_ATTR_ACC_FF:    rdata_q <= aff_q[attr_axis];
                    `NSG_ATTR_POS_PG:    rdata_q <= ppg_q[attr_axis];
                    `NSG_ATTR_POS_IG:    rdata_q <= pig_q[attr_axis];
                    `NSG_ATTR_VEL_PG:    rdata_q <= vpg_q[attr_axis];
                    `NSG_ATTR_VEL_IG:    rdata_q <= vig_q[attr_axis];
                    `NSG_ATTR_VEL_OFS:   rdata_q <= vofs_q[attr_axis];
                    `NSG_ATTR_TRQ_OFS:   rdata_q <= tofs_q[attr_axis];
                    `NSG_ATTR_LOOP_CFG:  rdata_q <= {30'h00000000, cfg_q[attr_axis]};
                    `NSG_ATTR_INT_HOLD:  rdata_q <= {31'h00000000, hold_q[attr_axis]};
                    `NSG_ATTR_OUT_LIM:   rdata_q <= lim_q[attr_axis];
                    `NSG_ATTR_POS_ERR:   rdata_q <= perr_q[attr_axis];
                    `NSG_ATTR_POS_INT:   rdata_q <= pint_q[attr_axis];
                    `NSG_ATTR_SERVO_OUT: rdata_q <= out_q[attr_axis];
                    default:             rdata_q <= `NSG_RST_WORD; // Unmapped
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Output packing
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NAX; g = g + 1)
        begin : g_out
            assign servo_out[g*W +: W] = out_q[g];
            assign servo_sat[g]        = sat_q[g];
        end
    endgenerate

    assign servo_strobe = strobe_q;
    assign attr_rdata   = rdata_q;
    assign attr_rvalid  = rvalid_q;

endmodule // nsg_loop

`default_nettype wire

// file: verification/nsg_monitor.sv
// Concurrent checks on the nested servo loop ports.
// Assumes binding onto nsg_loop, one clock mclk, reset rst active high.
`timescale 1ns/1ps
`default_nettype none
module nsg_monitor #(
    parameter NAX = 2,
    parameter W   = 32
) (
    // Clock and reset
    input wire logic             mclk,
    input wire logic             rst,
    // Observed ports
    input wire logic             coarse_tick,
    input wire logic             attr_rd,
    input wire logic [W-1:0]     attr_rdata,
    input wire logic             attr_rvalid,
    input wire logic [NAX*W-1:0] servo_out,
    input wire logic [NAX-1:0]   servo_sat,
    input wire logic             servo_strobe
);
    // ------------------------------------------------------------
    // Update timing
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_ans_lat;   coarse_tick |-> ##2 servo_strobe;                endproperty
    property p_ans_cause; servo_strobe |-> $past(coarse_tick, 2);          endproperty
    property p_pulse;     (!coarse_tick ##1 servo_strobe) |=> !servo_strobe; endproperty
    property p_out_hold;  !servo_strobe |-> $stable(servo_out);           endproperty
    property p_sat_out;   servo_sat[0] |-> servo_out[W-1:0] != '0;         endproperty
    a_ans_lat: assert property (p_ans_lat)
        else $error("no servo strobe two cycles after tick");
    a_ans_cause: assert property (p_ans_cause)
        else $error("servo strobe without tick");
    a_pulse: assert property (p_pulse)
        else $error("servo strobe longer than one cycle");
    a_out_hold: assert property (p_out_hold)
        else $error("servo output moved between updates");
    a_sat_out: assert property (p_sat_out)
        else $error("saturated with zero output");
    // ------------------------------------------------------------
    // Attribute get timing
    // ------------------------------------------------------------
    property p_get_ans;   attr_rd |=> attr_rvalid;                         endproperty
    property p_get_cause; attr_rvalid |-> $past(attr_rd);                  endproperty
    property p_rd_hold;   !attr_rvalid |-> $stable(attr_rdata);            endproperty
    a_get_ans: assert property (p_get_ans)
        else $error("get not answered next cycle");
    a_get_cause: assert property (p_get_cause)
        else $error("read valid without get");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without get");
    // Main scenarios reached
    c_update: cover property (servo_strobe);
    c_sat:    cover property (servo_sat[0]);
    c_get:    cover property (attr_rvalid);
endmodule // nsg_monitor
bind nsg_loop nsg_monitor #(.NAX(NAX), .W(W)) u_nsg_mon (.mclk(mclk), .rst(rst),
    .coarse_tick(coarse_tick), .attr_rd(attr_rd), .attr_rdata(attr_rdata),
    .attr_rvalid(attr_rvalid), .servo_out(servo_out), .servo_sat(servo_sat),
    .servo_strobe(servo_strobe));
`default_nettype wire

// file: verification/nsg_drive_model.sv
// External velocity loop drive: takes each servo word, reports feedback.
// Assumes position feedback is placed by the bench on fb_pos.
`timescale 1ns/1ps
`default_nettype none
module nsg_drive_model #(
    parameter NAX = 2,
    parameter W   = 32
) (
    // Clock and reset
    input wire logic             mclk,
    input wire logic             rst,
    // Command from the servo law
    input wire logic [NAX*W-1:0] servo_out,
    input wire logic             servo_strobe,
    // Position as set by the bench
    input wire logic [NAX*W-1:0] fb_pos,
    // Feedback to the servo law
    output logic     [NAX*W-1:0] act_pos,
    output logic     [NAX*W-1:0] act_vel
);
    // Drive closes its own velocity loop ideally: act_vel takes each strobed servo word
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            act_vel <= '0;
        else if (servo_strobe)
            act_vel <= servo_out;
    end
    // Encoder feedback passed straight through
    assign act_pos = fb_pos;
endmodule // nsg_drive_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the nested servo loop.
// Assumes nsg_loop with two axes and the drive model on its far side.
`timescale 1ns/1ps
`default_nettype none
`include "nsg_defs.vh"
module tb_top;
    // Stimulus and observed signals
    logic        mclk = 1'b0, rst = 1'b1, coarse_tick = 1'b0;
    logic [63:0] cmd_pos = '0, cmd_vel = '0, cmd_acc = '0, fb_pos = '0;
    logic [1:0]  cmd_moving = '0;
    logic        attr_wr = 1'b0, attr_rd = 1'b0, attr_axis = 1'b0;
    logic [4:0]  attr_id = '0;
    logic [31:0] attr_wdata = '0;
    wire  [31:0] attr_rdata;
    wire         attr_rvalid, servo_strobe;
    wire  [63:0] servo_out, act_pos, act_vel;
    wire  [1:0]  servo_sat;
    int          errors = 0, cmp_count = 0;
    always #50 mclk = ~mclk;
    nsg_loop dut (.mclk(mclk), .rst(rst), .coarse_tick(coarse_tick), .cmd_pos(cmd_pos),
        .cmd_vel(cmd_vel), .cmd_acc(cmd_acc), .act_pos(act_pos), .act_vel(act_vel),
        .cmd_moving(cmd_moving), .attr_wr(attr_wr), .attr_rd(attr_rd),
        .attr_axis(attr_axis), .attr_id(attr_id), .attr_wdata(attr_wdata),
        .attr_rdata(attr_rdata), .attr_rvalid(attr_rvalid), .servo_out(servo_out),
        .servo_sat(servo_sat), .servo_strobe(servo_strobe));
    nsg_drive_model drv (.mclk(mclk), .rst(rst), .servo_out(servo_out),
        .servo_strobe(servo_strobe), .fb_pos(fb_pos), .act_pos(act_pos), .act_vel(act_vel));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Set strobe for one cycle
    task automatic set_attr(input logic ax, input logic [4:0] id, input logic [31:0] d);
        @(posedge mclk);
        {attr_wr, attr_axis, attr_id, attr_wdata} <= {1'b1, ax, id, d};
        @(posedge mclk);
        attr_wr <= 1'b0;
    endtask
    task automatic set_both(input logic [4:0] id, input logic [31:0] d);
        set_attr(1'b0, id, d);
        set_attr(1'b1, id, d);
    endtask
    // Get strobe, then bounded wait for the answer
    task automatic get_attr(input logic ax, input logic [4:0] id, output logic [31:0] d);
        int n;
        @(posedge mclk);
        {attr_rd, attr_axis, attr_id} <= {1'b1, ax, id};
        @(posedge mclk);
        attr_rd <= 1'b0;
        #1;
        for (n = 0; n < 4 && attr_rvalid !== 1'b1; n++)
            @(posedge mclk) #1;
        d = attr_rdata;
        chk({31'h0, attr_rvalid}, 32'h1);
        chk(32'(n), 32'd0);
    endtask
    task automatic drive(input logic [63:0] cp, fp, cv, ca);
        @(posedge mclk);
        {cmd_pos, fb_pos, cmd_vel, cmd_acc} <= {cp, fp, cv, ca};
    endtask
    // One coarse update, bounded wait for the new output
    task automatic tick();
        int n;
        @(posedge mclk);
        coarse_tick <= 1'b1;
        @(posedge mclk);
        coarse_tick <= 1'b0;
        #1;
        for (n = 0; n < 4 && servo_strobe !== 1'b1; n++)
            @(posedge mclk) #1;
        chk({31'h0, servo_strobe}, 32'h1);
        chk(32'(n), 32'd1);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] d;
        for (int i = 0; i < 3; i++)
        begin
            get_attr(1'b1, 5'(i), d);
            chk(d, 32'h0);
            set_attr(1'b1, 5'(i), 32'h42c80000 + 32'(i));
            get_attr(1'b1, 5'(i), d);
            chk(d, 32'h42c80000 + 32'(i));
        end
        get_attr(1'b0, `NSG_ATTR_OUT_LIM, d);
        chk(d, 32'h7fffffff);
        set_attr(1'b0, `NSG_ATTR_POS_ERR, 32'h1234);
        get_attr(1'b0, `NSG_ATTR_POS_ERR, d);
        chk(d, 32'h0);
    endtask
    // Velocity servo into velocity drive: velocity offset added, torque offset and accel ignored
    task automatic t_veldrive();
        set_both(`NSG_ATTR_LOOP_CFG, 32'h3);
        set_both(`NSG_ATTR_VEL_OFS, 32'd5);
        set_both(`NSG_ATTR_TRQ_OFS, 32'd77);
        set_both(`NSG_ATTR_ACC_FF, 32'h42c80000);
        drive('0, '0, {32'd2000, 32'd1000}, {32'd300, 32'd300});
        tick();
        chk(servo_out[31:0], 32'd1005);
        chk(servo_out[63:32], 32'd2005);
        set_attr(1'b0, `NSG_ATTR_VEL_OFS, -32'sd5);
        tick();
        chk(servo_out[31:0], 32'd995);
    endtask
    // Position loop into velocity drive, both signs of error
    task automatic t_posloop();
        logic [31:0] p, d;
        set_both(`NSG_ATTR_LOOP_CFG, 32'h2);
        set_both(`NSG_ATTR_VEL_OFS, 32'd0);
        set_both(`NSG_ATTR_POS_PG, 32'h40000000);
        set_both(`NSG_ATTR_VEL_FF, 32'h42480000);
        drive({32'd100, 32'd100}, {32'd160, 32'd40}, {32'd1000, 32'd1000}, {32'd300, 32'd300});
        get_attr(1'b0, `NSG_ATTR_POS_INT, p);
        tick();
        chk(servo_out[31:0], 32'd620);
        chk(servo_out[63:32], 32'd380);
        get_attr(1'b1, `NSG_ATTR_POS_ERR, d);
        chk(d, -32'sd60);
        get_attr(1'b0, `NSG_ATTR_POS_INT, d);
        chk(p, 32'h0);
        chk(d, 32'd60);
    endtask
    // Integrator frozen when saturated or moving under hold
    task automatic t_sat();
        logic [31:0] p, d;
        set_attr(1'b0, `NSG_ATTR_OUT_LIM, 32'd100);
        get_attr(1'b0, `NSG_ATTR_POS_INT, p);
        chk(p, 32'd60);
        tick();
        chk(servo_out[31:0], 32'd100);
        chk({31'h0, servo_sat[0]}, 32'h1);
        get_attr(1'b0, `NSG_ATTR_POS_INT, d);
        chk(d, 32'd60);
        set_attr(1'b0, `NSG_ATTR_OUT_LIM, 32'h7fffffff);
        set_attr(1'b0, `NSG_ATTR_INT_HOLD, 32'h1);
        cmd_moving <= 2'b01;
        tick();
        chk({31'h0, servo_sat[0]}, 32'h0);
        get_attr(1'b0, `NSG_ATTR_POS_INT, d);
        chk(d, 32'd60);
        @(posedge mclk);
        cmd_moving <= 2'b00;
        tick();
        get_attr(1'b0, `NSG_ATTR_POS_INT, d);
        chk(d, 32'd120);
    endtask
    // Torque drive: accel term reaches the output
    task automatic t_torque();
        set_both(`NSG_ATTR_LOOP_CFG, 32'h0);
        set_both(`NSG_ATTR_TRQ_OFS, 32'd0);
        tick();
        chk(servo_out[31:0], 32'd300);
    endtask
    // Velocity servo on torque drive: internal velocity loop closed
    task automatic t_velloop();
        set_attr(1'b0, `NSG_ATTR_LOOP_CFG, 32'h1);
        set_attr(1'b0, `NSG_ATTR_VEL_PG, 32'h3f800000);
        set_attr(1'b0, `NSG_ATTR_TRQ_OFS, 32'd7);
        tick();
        chk(servo_out[31:0], 32'd1007);
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_veldrive();
        t_posloop();
        t_sat();
        t_torque();
        t_velloop();
        end_of_test();
    end
    initial
    begin
        repeat (5000) @(posedge mclk);
        errors++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
